// [cgr_clock_guard.sv]
// Clock safeguard, divider control and merged reset sequencing
// Notes on behaviour
// (R1) With safeguard on, internal clock never exceeds the safeguard maximum.
// (R2) Oscillator edges arriving too close together are dropped as spikes.
// (R3) Safeguard on: first missing main edge starts auxiliary oscillator as source.
// (R4) Safeguard and auxiliary access enabled by a fixed option, not a register.
// (R5) Divider control is write-only, resets to zero; bits 3,2 written zero.
// (R6) Divider select 00 divides by 1, 01 by 2, 10 and 11 by 4.
// (R7) Software keeps a RAM shadow since the divider control cannot be read.
// (R8) Software should leave safeguard off where precise timing is needed.
// (R9) Internal reset from pin, power-on, watchdog or low-voltage sources.
// (R10) Active-low reset pin works in any mode; reset holds while pin low.
// (R11) Pin reset in run/wait halts, pulls up I/O, restarts main oscillator.
// (R12) Pin reset in stop starts oscillator, pulls up I/O, delays then starts.
// (R13) Power-on holds reset, then counts stabilisation once oscillator runs.
// (R14) Watchdog timeout resets, clears watchdog, restarts like a pin reset.
// (R15) With low-voltage option, reset holds static while supply below reference.
// (R16) Low-voltage falling threshold sits below rising threshold for hysteresis.
// (R17) Internal reset sources drive the reset pin low.
// (R18) Auxiliary oscillator stops once main oscillator runs again.
// (R19) Converter control bit 2 stops main oscillator when set.
// (R20) One stabilisation counter, restarted by any source, releases on terminal count.
//
// Added by the designer: the strobed register port.
module cgr_clock_guard
	import cgr_pkg::*;
#(
	parameter bit SAFEGUARD_EN = 1'b1,
	parameter bit LVD_EN = 1'b1,
	parameter int STAB_CYCLES = CGR_STAB_CYCLES,
	parameter int MISS_CYCLES = CGR_MISS_CYCLES,
	parameter int SAFE_MIN_GAP = CGR_SAFE_MIN_GAP
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Register port
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrStb,
	input wire logic regRdStb,
	output logic [7:0] regRdData,
	// Oscillator and supply inputs (asynchronous)
	input wire logic mainOscIn,
	input wire logic auxOscIn,
	input wire logic powerOnDet,
	input wire logic supplyAboveRise,
	input wire logic supplyAboveFall,
	// Reset pin, open drain
	input wire logic resetPin_n_in,
	output logic resetPin_n_out,
	output logic resetPin_n_oe,
	// Core side
	input wire logic watchdogTimeout,
	input wire logic stopMode,
	output logic internalReset,
	output logic ioPullUpInputs,
	output logic watchdogClear,
	output logic cpuHalt,
	output logic mainOscEnable,
	output logic auxOscEnable,
	output logic clkSelAux,
	output logic intClkTick
);
	localparam int SCW = $clog2(STAB_CYCLES + 1);
	localparam int MCW = $clog2(MISS_CYCLES + 1);
	localparam int GW = $clog2(SAFE_MIN_GAP + 1);

	function automatic logic [1:0] divLimit(input logic [1:0] sel);
		unique case (sel)
			CGR_DIV1: divLimit = 2'h0;
			CGR_DIV2: divLimit = 2'h1;
			default: divLimit = 2'h3;
		endcase
	endfunction

	cgr_sync_if syncBus();
	logic mainOscS, auxOscS, pinLowS, porS;
	assign syncBus.raw = {powerOnDet, ~resetPin_n_in, auxOscIn, mainOscIn};
	assign mainOscS = syncBus.clean[0];
	assign auxOscS = syncBus.clean[1];
	assign pinLowS = syncBus.clean[2];
	assign porS = syncBus.clean[3];

	cgr_pin_sync #(.W(4)) uSync (
		.sys_clk(sys_clk),
		.rst(rst),
		.pins(syncBus)
	);

	// Register state
	logic [1:0] divSelReg;
	logic oscOffReg;
	logic [7:0] rdDataReg;
	logic wdClearReg;

	// Reset sequencing state
	cgr_state_e stateReg;
	logic [SCW-1:0] stabCntReg;
	logic lvdOkReg;
	logic srcInternal, srcAny;

	// Clock guard state
	logic mainPrevReg, auxPrevReg, auxSelReg;
	logic [MCW-1:0] missCntReg;
	logic [GW-1:0] gapCntReg;
	logic [1:0] divCntReg;
	logic mainEdge, auxEdge, srcEdge, filtEdge;

	// Register writes; divider control is write-only
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			divSelReg <= CGR_DIV_CTRL_RST[1:0];
			oscOffReg <= 1'b0;
		end else if (internalReset) begin
			divSelReg <= CGR_DIV_CTRL_RST[1:0]; // [R5]
			oscOffReg <= 1'b0; // [R11]
		end else if (regWrStb) begin
			if (regAddr == CGR_DIV_CTRL_ADDR) begin
				divSelReg <= regWrData[CGR_DIVSEL_LSB +: 2]; // [R5] [R6]
			end
			if (regAddr == CGR_CONV_CTRL_ADDR && SAFEGUARD_EN) begin
				oscOffReg <= regWrData[CGR_MAIN_OSC_OFF_BIT]; // [R19] [R4]
			end
		end
	end

	// Reads: divider control reads zero, status shows own state
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rdDataReg <= 8'h00;
		end else if (regRdStb) begin
			if (regAddr == CGR_CONV_CTRL_ADDR) begin
				rdDataReg <= {5'h00, oscOffReg, 2'h0};
			end else if (regAddr == CGR_STATUS_ADDR) begin
				rdDataReg <= {4'h0, lvdOkReg, auxSelReg, stateReg};
			end else begin
				rdDataReg <= 8'h00; // [R5]
			end
		end else begin
			rdDataReg <= 8'h00;
		end
	end
	assign regRdData = rdDataReg;

	// Low-voltage detector with two thresholds
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			lvdOkReg <= 1'b0;
		end else if (!lvdOkReg && supplyAboveRise) begin
			lvdOkReg <= 1'b1; // [R16]
		end else if (lvdOkReg && !supplyAboveFall) begin
			lvdOkReg <= 1'b0; // [R16]
		end
	end

	assign srcInternal = porS | watchdogTimeout
		| (LVD_EN & ~lvdOkReg); // [R9] [R15]
	assign srcAny = srcInternal | pinLowS; // [R9] [R10]

	// Stabilisation counter on active oscillator ticks
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			stateReg <= CGR_RESET;
			stabCntReg <= '0;
		end else if (srcAny) begin
			stateReg <= CGR_RESET; // [R10] [R20]
			stabCntReg <= '0;
		end else begin
			unique case (stateReg)
				CGR_RESET: begin
					stateReg <= CGR_STAB; // [R11] [R12]
					stabCntReg <= '0;
				end
				CGR_STAB: begin
					if (srcEdge) begin
						if (stabCntReg == SCW'(STAB_CYCLES - 1)) begin
							stateReg <= CGR_RUN; // [R13] [R20]
						end else begin
							stabCntReg <= stabCntReg + 1'b1;
						end
					end
				end
				CGR_RUN: stateReg <= CGR_RUN;
			endcase
		end
	end

	assign internalReset = (stateReg != CGR_RUN);
	assign ioPullUpInputs = internalReset; // [R11] [R12] [R13]
	assign cpuHalt = internalReset; // [R11]

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wdClearReg <= 1'b0;
		end else begin
			wdClearReg <= watchdogTimeout; // [R14]
		end
	end
	assign watchdogClear = wdClearReg;

	// Open-drain reset pin pulled low by internal sources
	assign resetPin_n_out = 1'b0;
	assign resetPin_n_oe = srcInternal; // [R17]

	// Main oscillator restarts on reset or cleared off bit
	assign mainOscEnable = ~oscOffReg | internalReset; // [R11] [R12] [R19]

	// Edge detection on filtered oscillator inputs
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			mainPrevReg <= 1'b0;
			auxPrevReg <= 1'b0;
		end else begin
			mainPrevReg <= mainOscS;
			auxPrevReg <= auxOscS;
		end
	end
	assign mainEdge = mainOscS & ~mainPrevReg;
	assign auxEdge = auxOscS & ~auxPrevReg;

	// Missing-edge watch and auxiliary switchover
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			missCntReg <= '0;
			auxSelReg <= 1'b0;
		end else if (!SAFEGUARD_EN) begin
			missCntReg <= '0; // [R4]
			auxSelReg <= 1'b0;
		end else if (mainEdge && mainOscEnable) begin
			missCntReg <= '0;
			auxSelReg <= 1'b0; // [R18]
		end else if (missCntReg == MCW'(MISS_CYCLES)) begin
			auxSelReg <= 1'b1; // [R3]
		end else begin
			missCntReg <= missCntReg + 1'b1;
		end
	end
	assign auxOscEnable = auxSelReg | (SAFEGUARD_EN & ~mainOscEnable);
	assign clkSelAux = auxSelReg;
	assign srcEdge = auxSelReg ? auxEdge : mainEdge;

	// Spike filter: minimum spacing between accepted edges
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			gapCntReg <= '0;
		end else if (filtEdge) begin
			gapCntReg <= GW'(SAFE_MIN_GAP);
		end else if (gapCntReg != '0) begin
			gapCntReg <= gapCntReg - 1'b1;
		end
	end
	assign filtEdge = srcEdge & (!SAFEGUARD_EN || gapCntReg == '0); // [R1] [R2]

	// Programmable divider on filtered edges
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			divCntReg <= 2'h0;
		end else if (filtEdge) begin
			divCntReg <= (divCntReg >= divLimit(divSelReg)) ? 2'h0
				: divCntReg + 2'h1; // [R6]
		end
	end
	assign intClkTick = filtEdge && (divCntReg >= divLimit(divSelReg));

	// Assertions
	sequence stabLast;
		stateReg == CGR_STAB && srcEdge && !srcAny
		&& stabCntReg == SCW'(STAB_CYCLES - 1);
	endsequence

	sequence missDone;
		SAFEGUARD_EN && missCntReg == MCW'(MISS_CYCLES) && !mainEdge;
	endsequence

	pinHold_a: assert property (@(posedge sys_clk) disable iff (rst) // [R10]
		pinLowS |=> internalReset)
		else $error("Reset released while pin low");

	pinDrive_a: assert property (@(posedge sys_clk) disable iff (rst) // [R17]
		srcInternal |-> resetPin_n_oe && !resetPin_n_out)
		else $error("Reset pin not driven low");

	spikeGap_a: assert property (@(posedge sys_clk) disable iff (rst) // [R2]
		(filtEdge && SAFEGUARD_EN) |=> !filtEdge [*2])
		else $error("Edges accepted too close");

	lvdHold_a: assert property (@(posedge sys_clk) disable iff (rst) // [R15]
		(LVD_EN && !lvdOkReg) |=> internalReset)
		else $error("Run while supply low");

	oscOn_a: assert property (@(posedge sys_clk) disable iff (rst) // [R11]
		internalReset |-> mainOscEnable)
		else $error("Main oscillator off in reset");

	wdClr_a: assert property (@(posedge sys_clk) disable iff (rst) // [R14]
		watchdogTimeout |=> watchdogClear && internalReset)
		else $error("Watchdog reset not applied");

	auxOff_a: assert property (@(posedge sys_clk) disable iff (rst) // [R18]
		(mainEdge && mainOscEnable) |=> !clkSelAux)
		else $error("Aux still selected");

	div1_a: assert property (@(posedge sys_clk) disable iff (rst) // [R6]
		(filtEdge && divSelReg == CGR_DIV1) |-> intClkTick)
		else $error("Divide by one missed tick");

	div2_a: assert property (@(posedge sys_clk) disable iff (rst) // [R6]
		(filtEdge && divSelReg == CGR_DIV2 && divCntReg == 2'h0)
		|-> !intClkTick)
		else $error("Divide by two ticked early");

	div4_a: assert property (@(posedge sys_clk) disable iff (rst) // [R6]
		(filtEdge && divSelReg[1] && divCntReg != 2'h3) |-> !intClkTick)
		else $error("Divide by four ticked early");

	stabRel_a: assert property (@(posedge sys_clk) disable iff (rst) // [R20]
		$rose(stateReg == CGR_RUN) |-> $past(stateReg) == CGR_STAB)
		else $error("Release without count");

	stabDone_a: assert property (@(posedge sys_clk) disable iff (rst) // [R20]
		stabLast |=> stateReg == CGR_RUN)
		else $error("Release missed at terminal count");

	srcReset_a: assert property (@(posedge sys_clk) disable iff (rst) // [R9]
		srcAny |=> stateReg == CGR_RESET)
		else $error("Reset source ignored");

	stopReset_a: assert property (@(posedge sys_clk) disable iff (rst) // [R12]
		(stopMode && pinLowS) |=> internalReset && mainOscEnable)
		else $error("Stop mode pin reset ignored");

	auxStart_a: assert property (@(posedge sys_clk) disable iff (rst) // [R3]
		missDone |=> clkSelAux)
		else $error("Aux not started");

	oscOffAux_a: assert property (@(posedge sys_clk) disable iff (rst) // [R3]
		(SAFEGUARD_EN && !mainOscEnable) |-> auxOscEnable)
		else $error("Aux not enabled with main off");

	noGuard_a: assert property (@(posedge sys_clk) disable iff (rst) // [R4]
		!SAFEGUARD_EN |-> !clkSelAux)
		else $error("Aux selected without safeguard");

	divClear_a: assert property (@(posedge sys_clk) disable iff (rst) // [R5]
		internalReset |=> divSelReg == CGR_DIV_CTRL_RST[1:0])
		else $error("Divider not cleared in reset");

	divRdZero_a: assert property (@(posedge sys_clk) disable iff (rst) // [R5]
		(regRdStb && regAddr == CGR_DIV_CTRL_ADDR) |=> regRdData == 8'h00)
		else $error("Divider control read back");

	rdIdle_a: assert property (@(posedge sys_clk) disable iff (rst) // [R5]
		!regRdStb |=> regRdData == 8'h00)
		else $error("Read data outside read cycle");

	lvdRise_a: assert property (@(posedge sys_clk) disable iff (rst) // [R16]
		(!lvdOkReg && supplyAboveRise) |=> lvdOkReg)
		else $error("Supply good not taken");

	lvdKeep_a: assert property (@(posedge sys_clk) disable iff (rst) // [R16]
		(lvdOkReg && supplyAboveFall) |=> lvdOkReg)
		else $error("Supply dropped above falling level");
endmodule // cgr_clock_guard

// [cgr_osc_model.sv]
// Oscillator and reset-pin model at the far side of the clock guard
module cgr_osc_model (
	// Controls from the bench
	input wire logic mainRun,
	input wire logic fast,
	input wire logic extLow,
	// From the block
	input wire logic mainOscEnable,
	input wire logic auxOscEnable,
	input wire logic resetPin_n_oe,
	// To the block
	output logic mainOsc,
	output logic auxOsc,
	output wire logic resetPin_n
);
	timeunit 1ns;
	timeprecision 100ps;
	initial mainOsc = 1'b0;
	initial auxOsc = 1'b0;
	// Main oscillator freezes when stopped or switched off
	always begin
		#(fast ? 45 : 83);
		if (mainRun && mainOscEnable !== 1'b0) begin
			mainOsc = ~mainOsc;
		end
	end
	// Auxiliary oscillator runs only while enabled
	always begin
		#230;
		auxOsc = (auxOscEnable === 1'b1) ? ~auxOsc : 1'b0;
	end
	// Pull-up pin, pulled low by either party
	assign resetPin_n = ~(extLow | resetPin_n_oe);
endmodule // cgr_osc_model

// [cgr_pin_sync.sv]
// Three-flop pin synchroniser with agreement filter
module cgr_pin_sync #(
	parameter int W = 4
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Pins
	cgr_sync_if.sync pins
);
	logic [W-1:0] s1Reg, s2Reg, s3Reg, cleanReg;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s1Reg <= '0;
			s2Reg <= '0;
			s3Reg <= '0;
		end else begin
			s1Reg <= pins.raw;
			s2Reg <= s1Reg;
			s3Reg <= s2Reg;
		end
	end
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : gAgree
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					cleanReg[i] <= 1'b0;
				end else if (s2Reg[i] == s3Reg[i]) begin
					cleanReg[i] <= s3Reg[i];
				end
			end
		end
	endgenerate
	assign pins.clean = cleanReg;
endmodule // cgr_pin_sync

// [cgr_pkg.sv]
// Package: constants for the clock guard and reset control block
package cgr_pkg;
	localparam logic [7:0] CGR_DIV_CTRL_ADDR = 8'hdc;
	localparam logic [7:0] CGR_CONV_CTRL_ADDR = 8'hd1;
	localparam logic [7:0] CGR_STATUS_ADDR = 8'hde;
	localparam logic [7:0] CGR_DIV_CTRL_RST = 8'h00;
	localparam int CGR_DIVSEL_LSB = 0;
	localparam int CGR_MAIN_OSC_OFF_BIT = 2;
	localparam logic [1:0] CGR_DIV1 = 2'h0;
	localparam logic [1:0] CGR_DIV2 = 2'h1;
	localparam int CGR_STAB_CYCLES = 4096;
	localparam int CGR_MISS_CYCLES = 4;
	localparam int CGR_SAFE_MIN_GAP = 2;
	typedef enum logic [1:0] {CGR_RESET, CGR_STAB, CGR_RUN} cgr_state_e;
endpackage

// [cgr_sync_if.sv]
// Interface: synchroniser pin bundle
interface cgr_sync_if;
	logic [3:0] raw;
	logic [3:0] clean;
	modport sync (input raw, output clean);
	modport user (output raw, input clean);
endinterface

// [clock_guard_and_reset_control_tb.sv]
// Self-checking bench for the clock guard and reset control block
`define CHK(a, e) begin testsRun++; if ((a) !== (e)) begin errTotal++; \
	$display("unexpected at %0t: got %h exp %h", $time, a, e); end end
module clock_guard_and_reset_control_tb import cgr_pkg::*; ;
	timeunit 1ns;
	timeprecision 100ps;
	logic sys_clk = 1'b0, rst = 1'b1;
	logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, d, divShadow;
	logic regWrStb = 1'b0, regRdStb = 1'b0, powerOnDet = 1'b1;
	logic supplyAboveRise = 1'b1, supplyAboveFall = 1'b1, stopMode = 1'b0;
	logic watchdogTimeout = 1'b0, extLow = 1'b0, mainRun = 1'b1, fast = 1'b0;
	logic mainOsc, auxOsc, pinLevel, resetPin_n_oe, internalReset;
	logic ioPullUpInputs, watchdogClear, cpuHalt, mainOscEnable;
	logic auxOscEnable, clkSelAux, intClkTick;
	int errTotal = 0, testsRun = 0, t[4], tf;
	initial forever #20 sys_clk = ~sys_clk;
	cgr_clock_guard #(.STAB_CYCLES(8)) u_cgr_clock_guard (.sys_clk, .rst,
		.regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData,
		.mainOscIn(mainOsc), .auxOscIn(auxOsc), .powerOnDet,
		.supplyAboveRise, .supplyAboveFall, .resetPin_n_in(pinLevel),
		.resetPin_n_out(), .resetPin_n_oe, .watchdogTimeout, .stopMode,
		.internalReset, .ioPullUpInputs, .watchdogClear, .cpuHalt,
		.mainOscEnable, .auxOscEnable, .clkSelAux, .intClkTick);
	cgr_osc_model u_cgr_osc_model (.mainRun, .fast, .extLow,
		.mainOscEnable, .auxOscEnable, .resetPin_n_oe, .mainOsc,
		.auxOsc, .resetPin_n(pinLevel));
	task automatic reportAndStop();
		$display("comparisons %0d mismatches %0d", testsRun, errTotal);
		if (errTotal == 0 && testsRun > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		regAddr <= a;
		regWrData <= v;
		regWrStb <= 1'b1;
		@(posedge sys_clk);
		regWrStb <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge sys_clk);
		regAddr <= a;
		regRdStb <= 1'b1;
		@(posedge sys_clk);
		regRdStb <= 1'b0;
		@(negedge sys_clk);
		v = regRdData;
	endtask
	// Shadow copy is updated before the register itself
	task automatic wrDiv(input logic [7:0] v);
		divShadow = v;
		wr(CGR_DIV_CTRL_ADDR, v);
	endtask
	task automatic giveUp();
		errTotal++;
		$display("unexpected at %0t: wait ran out", $time);
		reportAndStop();
	endtask
	task automatic waitRst(input logic lvl);
		for (int i = 0; i < 800 && internalReset !== lvl; i++) begin
			@(negedge sys_clk);
		end
		if (internalReset !== lvl) begin
			giveUp();
		end
	endtask
	task automatic waitAux(input logic lvl);
		for (int i = 0; i < 800 && clkSelAux !== lvl; i++) begin
			@(negedge sys_clk);
		end
		if (clkSelAux !== lvl) begin
			giveUp();
		end
	endtask
	task automatic countTicks(output int n);
		n = 0;
		repeat (80) begin
			@(negedge sys_clk);
			n += (intClkTick === 1'b1);
		end
	endtask
	initial begin
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (40) @(posedge sys_clk);
		`CHK(internalReset, 1'b1)
		`CHK(ioPullUpInputs, 1'b1)
		`CHK(resetPin_n_oe, 1'b1)
		powerOnDet <= 1'b0;
		waitRst(1'b0);
		rd(CGR_STATUS_ADDR, d);
		`CHK(d[1:0], 2'h2)
		wrDiv(8'h01);
		rd(CGR_DIV_CTRL_ADDR, d);
		`CHK(d, 8'h00)
		rd(8'h55, d);
		`CHK(d, 8'h00)
		$display("test power-on and access done");
		for (int k = 0; k < 4; k++) begin
			wrDiv(8'(k));
			countTicks(t[k]);
		end
		`CHK(t[0] > 0 && t[0] <= 2*t[1] + 2 && t[0] + 2 >= 2*t[1], 1'b1)
		`CHK(t[1] <= 2*t[2] + 2 && t[1] + 2 >= 2*t[2], 1'b1)
		`CHK(t[2] <= t[3] + 1 && t[2] + 1 >= t[3], 1'b1)
		wrDiv(8'h00);
		fast <= 1'b1;
		countTicks(tf);
		`CHK(tf <= 80/CGR_SAFE_MIN_GAP + 1, 1'b1)
		fast <= 1'b0;
		$display("test divider and spikes done");
		for (int m = 0; m < 2; m++) begin
			wrDiv(8'h02);
			stopMode <= m[0];
			extLow <= 1'b1;
			repeat (60) @(posedge sys_clk);
			`CHK(internalReset, 1'b1)
			`CHK(cpuHalt & ioPullUpInputs, 1'b1)
			`CHK(mainOscEnable, 1'b1)
			extLow <= 1'b0;
			waitRst(1'b0);
			countTicks(tf);
			`CHK(tf <= t[0] + 2 && tf + 2 >= t[0], 1'b1)
		end
		$display("test reset pin done");
		@(posedge sys_clk);
		watchdogTimeout <= 1'b1;
		@(negedge sys_clk);
		`CHK(resetPin_n_oe, 1'b1)
		@(posedge sys_clk);
		watchdogTimeout <= 1'b0;
		@(negedge sys_clk);
		`CHK(watchdogClear, 1'b1)
		repeat (4) @(negedge sys_clk);
		`CHK(internalReset & ioPullUpInputs, 1'b1)
		waitRst(1'b0);
		$display("test watchdog done");
		supplyAboveRise <= 1'b0;
		repeat (20) @(posedge sys_clk);
		`CHK(internalReset, 1'b0)
		supplyAboveFall <= 1'b0;
		repeat (8) @(posedge sys_clk);
		`CHK(internalReset & resetPin_n_oe, 1'b1)
		supplyAboveFall <= 1'b1;
		repeat (60) @(posedge sys_clk);
		`CHK(internalReset, 1'b1)
		supplyAboveRise <= 1'b1;
		waitRst(1'b0);
		$display("test low voltage done");
		mainRun <= 1'b0;
		waitAux(1'b1);
		rd(CGR_STATUS_ADDR, d);
		`CHK(d[2], 1'b1)
		mainRun <= 1'b1;
		waitAux(1'b0);
		wr(CGR_CONV_CTRL_ADDR, 8'h04);
		@(negedge sys_clk);
		`CHK(mainOscEnable, 1'b0)
		waitAux(1'b1);
		rd(CGR_CONV_CTRL_ADDR, d);
		`CHK(d[CGR_MAIN_OSC_OFF_BIT], 1'b1)
		wr(CGR_CONV_CTRL_ADDR, 8'h00);
		@(negedge sys_clk);
		`CHK(mainOscEnable, 1'b1)
		waitAux(1'b0);
		$display("test auxiliary oscillator done");
		reportAndStop();
	end
endmodule // clock_guard_and_reset_control_tb
